/* logic/bsr_scan_port.sv */
// Boundary-scan chain, instruction decode and pin control of the test port.
`timescale 1ns/100ps
`default_nettype none
`include "bsr_defines.svh"

module bsr_scan_port #(
	parameter int          CHAIN_LEN  = `BSR_CHAIN_DEFAULT,
	parameter int          N_CLKIN    = 4,
	parameter int          N_DIN      = 8,
	parameter int          N_OD       = 2,
	parameter int          N_DOUT     = 1,
	parameter logic [31:0] ID_VALUE   = 32'h1234_5001, // arbitrary value
	parameter logic [31:0] USER_VALUE = 32'hFFFF_FFFF,
	// User cell count, fixed by the chain length and the dedicated pins
	localparam int         N_USER     = CHAIN_LEN / `BSR_CELL_W -
		(N_CLKIN + N_DIN + N_OD + 1 + N_DOUT)
) (
	// System clock domain
	input  wire logic                  ref_clk,
	input  wire logic                  reset_n,
	input  wire logic                  clk_en,
	// Test port pins
	input  wire logic                  tck,
	input  wire logic                  trst_n,
	input  wire logic                  tms,
	input  wire logic                  tdi,
	output logic                       tdo,
	output logic                       tdo_oe,
	// User I/O cells
	input  wire logic [N_USER-1:0]     core_output_value,
	input  wire logic [N_USER-1:0]     core_output_enable,
	input  wire logic [N_USER-1:0]     pad_input_value,
	output logic      [N_USER-1:0]     pad_output_drive,
	output logic      [N_USER-1:0]     pad_enable_drive,
	output logic      [N_USER-1:0]     core_input_override,
	output logic                       global_tristate,
	// Dedicated pin cells, capture only
	input  wire logic [N_CLKIN-1:0]    clkin_pad_value,
	input  wire logic [N_DIN-1:0]      ctrl_in_pad_value,
	input  wire logic [N_OD-1:0]       od_core_enable,
	input  wire logic [N_OD-1:0]       od_pad_value,
	input  wire logic                  cfgclk_core_value,
	input  wire logic                  cfgclk_core_enable,
	input  wire logic                  cfgclk_pad_value,
	input  wire logic [N_DOUT-1:0]     dout_core_value,
	// Reconfiguration request, system clock
	output logic                       config_request_pulse,
	// I/O setup shift chain, test clock
	output logic                       io_setup_shift_chain_shift,
	output logic                       io_setup_shift_chain_capture,
	output logic                       io_setup_shift_chain_update,
	output logic                       scan_serial_out,
	input  wire logic                  scan_serial_in
);

	// ****************************************************************
	// Chain geometry
	// ****************************************************************
	localparam int N_CELLS = CHAIN_LEN / `BSR_CELL_W;
	localparam int N_DED   = N_CLKIN + N_DIN + N_OD + 1 + N_DOUT;
	localparam int UPD_W   = N_USER * `BSR_CELL_W;
	localparam int B_CLKIN = N_USER;
	localparam int B_DIN   = B_CLKIN + N_CLKIN;
	localparam int B_OD    = B_DIN + N_DIN;
	localparam int B_CFGCK = B_OD + N_OD;
	localparam int B_DOUT  = B_CFGCK + 1;

	// ****************************************************************
	// Helpers
	// ****************************************************************
	// Pack one three-bit cell
	function automatic logic [2:0] cell3(input logic o, input logic e,
		input logic i);
		logic [2:0] c;
		c                = 3'h0;
		c[`BSR_CELL_OUT] = o;
		c[`BSR_CELL_OE]  = e;
		c[`BSR_CELL_IN]  = i;
		return c;
	endfunction : cell3

	// Map an opcode to its action; anything unknown behaves as bypass
	function automatic bsr_pkg::bsr_instr_t decode(
		input logic [`BSR_IR_W-1:0] op);
		case (op)
			`BSR_OP_SAMPLE:    decode = bsr_pkg::BSR_INS_SAMPLE;
			`BSR_OP_EXTEST:    decode = bsr_pkg::BSR_INS_EXTEST;
			`BSR_OP_USERCODE:  decode = bsr_pkg::BSR_INS_USERCODE;
			`BSR_OP_IDCODE:    decode = bsr_pkg::BSR_INS_IDCODE;
			`BSR_OP_HIGHZ:     decode = bsr_pkg::BSR_INS_HIGHZ;
			`BSR_OP_CLAMP:     decode = bsr_pkg::BSR_INS_CLAMP;
			`BSR_OP_CONFIG_IO: decode = bsr_pkg::BSR_INS_CONFIG;
			default:           decode = bsr_pkg::BSR_INS_BYPASS;
		endcase
	endfunction : decode

	// ****************************************************************
	// Controller, test clock domain
	// ****************************************************************
	bsr_pkg::bsr_state_t state_q;
	bsr_pkg::bsr_state_t state_d;

	// Next state from TMS, sampled on the rising edge
	always_comb begin
		unique case (state_q)
			bsr_pkg::BSR_RESET:
				state_d = tms ? bsr_pkg::BSR_RESET : bsr_pkg::BSR_IDLE;
			bsr_pkg::BSR_IDLE:
				state_d = tms ? bsr_pkg::BSR_SEL_DR : bsr_pkg::BSR_IDLE;
			bsr_pkg::BSR_SEL_DR:
				state_d = tms ? bsr_pkg::BSR_SEL_IR : bsr_pkg::BSR_CAPTURE_DR;
			bsr_pkg::BSR_CAPTURE_DR:
				state_d = tms ? bsr_pkg::BSR_EXIT1_DR : bsr_pkg::BSR_SHIFT_DR;
			bsr_pkg::BSR_SHIFT_DR:
				state_d = tms ? bsr_pkg::BSR_EXIT1_DR : bsr_pkg::BSR_SHIFT_DR;
			bsr_pkg::BSR_EXIT1_DR:
				state_d = tms ? bsr_pkg::BSR_UPDATE_DR : bsr_pkg::BSR_PAUSE_DR;
			bsr_pkg::BSR_PAUSE_DR:
				state_d = tms ? bsr_pkg::BSR_EXIT2_DR : bsr_pkg::BSR_PAUSE_DR;
			bsr_pkg::BSR_EXIT2_DR:
				state_d = tms ? bsr_pkg::BSR_UPDATE_DR : bsr_pkg::BSR_SHIFT_DR;
			bsr_pkg::BSR_UPDATE_DR:
				state_d = tms ? bsr_pkg::BSR_SEL_DR : bsr_pkg::BSR_IDLE;
			bsr_pkg::BSR_SEL_IR:
				state_d = tms ? bsr_pkg::BSR_RESET : bsr_pkg::BSR_CAPTURE_IR;
			bsr_pkg::BSR_CAPTURE_IR:
				state_d = tms ? bsr_pkg::BSR_EXIT1_IR : bsr_pkg::BSR_SHIFT_IR;
			bsr_pkg::BSR_SHIFT_IR:
				state_d = tms ? bsr_pkg::BSR_EXIT1_IR : bsr_pkg::BSR_SHIFT_IR;
			bsr_pkg::BSR_EXIT1_IR:
				state_d = tms ? bsr_pkg::BSR_UPDATE_IR : bsr_pkg::BSR_PAUSE_IR;
			bsr_pkg::BSR_PAUSE_IR:
				state_d = tms ? bsr_pkg::BSR_EXIT2_IR : bsr_pkg::BSR_PAUSE_IR;
			bsr_pkg::BSR_EXIT2_IR:
				state_d = tms ? bsr_pkg::BSR_UPDATE_IR : bsr_pkg::BSR_SHIFT_IR;
			bsr_pkg::BSR_UPDATE_IR:
				state_d = tms ? bsr_pkg::BSR_SEL_DR : bsr_pkg::BSR_IDLE;
		endcase
	end

	// State register; the pin reset forces the reset state at once
	always_ff @(posedge tck or negedge trst_n) begin
		if (!trst_n) begin
			state_q <= bsr_pkg::BSR_RESET;
		end else begin
			state_q <= state_d;
		end
	end

	// Strobes shared by every cell, made here and nowhere else
	logic cap_dr, sh_dr, upd_dr, cap_ir, sh_ir, upd_ir;
	assign cap_dr = (state_q == bsr_pkg::BSR_CAPTURE_DR);
	assign sh_dr  = (state_q == bsr_pkg::BSR_SHIFT_DR);
	assign upd_dr = (state_q == bsr_pkg::BSR_UPDATE_DR);
	assign cap_ir = (state_q == bsr_pkg::BSR_CAPTURE_IR);
	assign sh_ir  = (state_q == bsr_pkg::BSR_SHIFT_IR);
	assign upd_ir = (state_q == bsr_pkg::BSR_UPDATE_IR);

	// ****************************************************************
	// Instruction register
	// ****************************************************************
	logic [`BSR_IR_W-1:0] ir_sh_q;
	logic [`BSR_IR_W-1:0] ir_q;
	bsr_pkg::bsr_instr_t  ins;
	assign ins = decode(ir_q);

	// Shift stage: fixed capture pattern, then data from the serial input
	always_ff @(posedge tck or negedge trst_n) begin
		if (!trst_n) begin
			ir_sh_q <= `BSR_IR_CAPTURE;
		end else if (cap_ir) begin
			ir_sh_q <= `BSR_IR_CAPTURE;
		end else if (sh_ir) begin
			ir_sh_q <= {tdi, ir_sh_q[`BSR_IR_W-1:1]};
		end
	end

	// Active instruction; the reset state always reloads the identifier
	always_ff @(posedge tck or negedge trst_n) begin
		if (!trst_n) begin
			ir_q <= `BSR_OP_IDCODE;
		end else if (state_q == bsr_pkg::BSR_RESET) begin
			ir_q <= `BSR_OP_IDCODE;
		end else if (upd_ir) begin
			ir_q <= ir_sh_q;
		end
	end

	// Reconfiguration request as an event toggle toward the system clock
	logic reconf_tgl_q;
	always_ff @(posedge tck or negedge trst_n) begin
		if (!trst_n) begin
			reconf_tgl_q <= 1'b0;
		end else if (upd_ir && ir_sh_q == `BSR_OP_RECONFIG) begin
			reconf_tgl_q <= ~reconf_tgl_q;
		end
	end

	// ****************************************************************
	// Capture sources, brought onto the test clock
	// ****************************************************************
	logic [CHAIN_LEN-1:0] cap_raw;
	logic [CHAIN_LEN-1:0] cap_s1_q;
	logic [CHAIN_LEN-1:0] cap_s2_q;

	// Cell contents by pin class; leftover chain bits read zero
	always_comb begin
		cap_raw = '0;
		for (int i = 0; i < N_USER; i++) begin
			cap_raw[i*3 +: 3] = cell3(core_output_value[i],
				core_output_enable[i], pad_input_value[i]);
		end
		for (int i = 0; i < N_CLKIN; i++) begin
			cap_raw[(B_CLKIN+i)*3 +: 3] = cell3(`BSR_CAP_LOW,
				`BSR_CAP_HIGH, clkin_pad_value[i]);
		end
		for (int i = 0; i < N_DIN; i++) begin
			cap_raw[(B_DIN+i)*3 +: 3] = cell3(`BSR_CAP_LOW,
				`BSR_CAP_HIGH, ctrl_in_pad_value[i]);
		end
		for (int i = 0; i < N_OD; i++) begin
			cap_raw[(B_OD+i)*3 +: 3] = cell3(`BSR_CAP_LOW,
				od_core_enable[i], od_pad_value[i]);
		end
		cap_raw[B_CFGCK*3 +: 3] = cell3(cfgclk_core_value,
			cfgclk_core_enable, cfgclk_pad_value);
		for (int i = 0; i < N_DOUT; i++) begin
			cap_raw[(B_DOUT+i)*3 +: 3] = cell3(dout_core_value[i],
				`BSR_CAP_LOW, `BSR_CAP_LOW);
		end
	end

	// Two-stage synchroniser; pins and core are foreign to the test clock
	always_ff @(posedge tck or negedge trst_n) begin
		if (!trst_n) begin
			cap_s1_q <= '0;
			cap_s2_q <= '0;
		end else begin
			cap_s1_q <= cap_raw;
			cap_s2_q <= cap_s1_q;
		end
	end

	// ****************************************************************
	// Data registers
	// ****************************************************************
	logic [CHAIN_LEN-1:0] bsr_q;
	logic [UPD_W-1:0]     upd_q;
	logic                 byp_q;
	logic [`BSR_ID_W-1:0] id_q;

	// Boundary chain: capture, then shift toward the serial output
	always_ff @(posedge tck or negedge trst_n) begin
		if (!trst_n) begin
			bsr_q <= '0;
		end else if (ins == bsr_pkg::BSR_INS_SAMPLE ||
			ins == bsr_pkg::BSR_INS_EXTEST) begin
			if (cap_dr) begin
				bsr_q <= cap_s2_q;
			end else if (sh_dr) begin
				bsr_q <= {tdi, bsr_q[CHAIN_LEN-1:1]};
			end
		end
	end

	// Update stages exist for user cells only; dedicated pins have none
	always_ff @(posedge tck or negedge trst_n) begin
		if (!trst_n) begin
			upd_q <= '0;
		end else if (upd_dr && (ins == bsr_pkg::BSR_INS_SAMPLE ||
			ins == bsr_pkg::BSR_INS_EXTEST)) begin
			upd_q <= bsr_q[UPD_W-1:0];
		end
	end

	// Single bypass bit, captured as zero
	always_ff @(posedge tck or negedge trst_n) begin
		if (!trst_n) begin
			byp_q <= 1'b0;
		end else if (cap_dr) begin
			byp_q <= 1'b0;
		end else if (sh_dr) begin
			byp_q <= tdi;
		end
	end

	// Identification register: fixed code or the user value
	always_ff @(posedge tck or negedge trst_n) begin
		if (!trst_n) begin
			id_q <= '0;
		end else if (cap_dr) begin
			id_q <= (ins == bsr_pkg::BSR_INS_USERCODE) ?
				USER_VALUE : ID_VALUE;
		end else if (sh_dr) begin
			id_q <= {tdi, id_q[`BSR_ID_W-1:1]};
		end
	end

	// I/O setup chain strobes, given only under its instruction
	logic cfg_sel;
	assign cfg_sel = (ins == bsr_pkg::BSR_INS_CONFIG);
	assign io_setup_shift_chain_shift   = cfg_sel & sh_dr;
	assign io_setup_shift_chain_capture = cfg_sel & cap_dr;
	assign io_setup_shift_chain_update  = cfg_sel & upd_dr;
	assign scan_serial_out              = tdi;

	// ****************************************************************
	// Serial output, changed on the falling edge
	// ****************************************************************
	logic dr_out;
	always_comb begin
		unique case (ins)
			bsr_pkg::BSR_INS_SAMPLE,
			bsr_pkg::BSR_INS_EXTEST:   dr_out = bsr_q[0];
			bsr_pkg::BSR_INS_USERCODE,
			bsr_pkg::BSR_INS_IDCODE:   dr_out = id_q[0];
			bsr_pkg::BSR_INS_CONFIG:   dr_out = scan_serial_in;
			bsr_pkg::BSR_INS_BYPASS,
			bsr_pkg::BSR_INS_HIGHZ,
			bsr_pkg::BSR_INS_CLAMP:    dr_out = byp_q;
		endcase
	end

	// Enable follows the shift states one half clock later
	always_ff @(negedge tck or negedge trst_n) begin
		if (!trst_n) begin
			tdo    <= 1'b0;
			tdo_oe <= 1'b0;
		end else begin
			tdo    <= sh_ir ? ir_sh_q[0] : dr_out;
			tdo_oe <= sh_ir | sh_dr;
		end
	end

	// Pin-side mode bits, registered so the crossing sees clean levels
	logic mode_q, hiz_q, force_in_q;
	always_ff @(posedge tck or negedge trst_n) begin
		if (!trst_n) begin
			mode_q     <= 1'b0;
			hiz_q      <= 1'b0;
			force_in_q <= 1'b0;
		end else begin
			mode_q     <= ins == bsr_pkg::BSR_INS_EXTEST ||
				ins == bsr_pkg::BSR_INS_CLAMP;
			hiz_q      <= ins == bsr_pkg::BSR_INS_HIGHZ;
			force_in_q <= ins == bsr_pkg::BSR_INS_EXTEST;
		end
	end

	// ****************************************************************
	// System clock side: pin drive and reconfiguration pulse
	// ****************************************************************
	// Update data only moves between updates, so a vector sync is safe
	logic [UPD_W-1:0]  upd_s1_q, upd_s2_q;
	logic [2:0]        md_s1_q, md_s2_q;
	logic [N_USER-1:0] pin_s1_q, pin_s2_q;
	logic [2:0]        rc_q;

	// Level synchronisers; clk_en freezes this domain
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			upd_s1_q <= '0;
			upd_s2_q <= '0;
			md_s1_q  <= 3'h0;
			md_s2_q  <= 3'h0;
			pin_s1_q <= '0;
			pin_s2_q <= '0;
		end else if (clk_en) begin
			upd_s1_q <= upd_q;
			upd_s2_q <= upd_s1_q;
			md_s1_q  <= {force_in_q, hiz_q, mode_q};
			md_s2_q  <= md_s1_q;
			pin_s1_q <= pad_input_value;
			pin_s2_q <= pin_s1_q;
		end
	end

	// Toggle detector; only the second and third stages are compared
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rc_q                 <= 3'h0;
			config_request_pulse <= 1'b0;
		end else if (clk_en) begin
			rc_q                 <= {rc_q[1:0], reconf_tgl_q};
			config_request_pulse <= rc_q[2] ^ rc_q[1];
		end
	end

	// Cell output muxes; the tri-state term overrides every enable
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			pad_output_drive    <= '0;
			pad_enable_drive    <= '0;
			core_input_override <= '0;
			global_tristate     <= 1'b0;
		end else if (clk_en) begin
			global_tristate <= md_s2_q[1];
			for (int i = 0; i < N_USER; i++) begin
				pad_output_drive[i] <= md_s2_q[0] ?
					upd_s2_q[i*3+`BSR_CELL_OUT] :
					core_output_value[i];
				pad_enable_drive[i] <= md_s2_q[1] ? 1'b0 :
					(md_s2_q[0] ? upd_s2_q[i*3+`BSR_CELL_OE] :
					core_output_enable[i]);
				core_input_override[i] <= md_s2_q[2] ?
					upd_s2_q[i*3+`BSR_CELL_IN] : pin_s2_q[i];
			end
		end
	end

	// Test pins, supplies, references and diodes never enter cap_raw
	// and so have no place in the chain.

endmodule : bsr_scan_port
`default_nettype wire

/* pkg/bsr_defines.svh */
// Constants of the boundary-scan test port: codes, widths, field positions.
`ifndef BSR_DEFINES_SVH
`define BSR_DEFINES_SVH

// ****************************************************************
// Instruction register
// ****************************************************************
`define BSR_IR_W          10
`define BSR_IR_CAPTURE    10'h001
`define BSR_OP_SAMPLE     10'h005
`define BSR_OP_EXTEST     10'h00F
`define BSR_OP_BYPASS     10'h3FF
`define BSR_OP_USERCODE   10'h007
`define BSR_OP_IDCODE     10'h006
`define BSR_OP_HIGHZ      10'h00B
`define BSR_OP_CLAMP      10'h00A
`define BSR_OP_RECONFIG   10'h001
`define BSR_OP_CONFIG_IO  10'h00D

// ****************************************************************
// Data registers and cell layout
// ****************************************************************
`define BSR_ID_W          32
`define BSR_CELL_W        3
`define BSR_CELL_OUT      2
`define BSR_CELL_OE       1
`define BSR_CELL_IN       0
`define BSR_CAP_LOW       1'b0
`define BSR_CAP_HIGH      1'b1
`define BSR_CHAIN_DEFAULT 1506

`endif

/* pkg/bsr_pkg.sv */
// Types shared by the boundary-scan test port.
`default_nettype none
package bsr_pkg;

	// ****************************************************************
	// Controller states, Gray steps along the usual path
	// ****************************************************************
	typedef enum logic [3:0] {
		BSR_RESET      = 4'h0,
		BSR_IDLE       = 4'h1,
		BSR_SEL_DR     = 4'h3,
		BSR_CAPTURE_DR = 4'h2,
		BSR_SHIFT_DR   = 4'h6,
		BSR_EXIT1_DR   = 4'h7,
		BSR_PAUSE_DR   = 4'h5,
		BSR_EXIT2_DR   = 4'h4,
		BSR_UPDATE_DR  = 4'hC,
		BSR_SEL_IR     = 4'hD,
		BSR_CAPTURE_IR = 4'hF,
		BSR_SHIFT_IR   = 4'hE,
		BSR_EXIT1_IR   = 4'hA,
		BSR_PAUSE_IR   = 4'hB,
		BSR_EXIT2_IR   = 4'h9,
		BSR_UPDATE_IR  = 4'h8
	} bsr_state_t;

	// ****************************************************************
	// Decoded instruction
	// ****************************************************************
	typedef enum logic [2:0] {
		BSR_INS_BYPASS   = 3'h0,
		BSR_INS_SAMPLE   = 3'h1,
		BSR_INS_EXTEST   = 3'h2,
		BSR_INS_USERCODE = 3'h3,
		BSR_INS_IDCODE   = 3'h4,
		BSR_INS_HIGHZ    = 3'h5,
		BSR_INS_CLAMP    = 3'h6,
		BSR_INS_CONFIG   = 3'h7
	} bsr_instr_t;

endpackage : bsr_pkg
`default_nettype wire

/* tb/bsr_scan_port_asserts.sv */
// Concurrent checks on the pins of the boundary-scan test port.
`timescale 1ns/100ps
`default_nettype none
module bsr_scan_port_asserts (
	// System side
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic global_tristate,
	input wire logic config_request_pulse,
	// Test clock side
	input wire logic tck,
	input wire logic trst_n,
	input wire logic tdi,
	input wire logic tdo_oe,
	input wire logic io_setup_shift_chain_shift,
	input wire logic io_setup_shift_chain_capture,
	input wire logic io_setup_shift_chain_update,
	input wire logic scan_serial_out
);
	// ****************************************************************
	// Test clock domain
	// ****************************************************************
	// Strobes follow controller states, so never two at once
	a_strobe_excl: assert property (@(posedge tck) disable iff (!trst_n)
		$onehot0({io_setup_shift_chain_shift, io_setup_shift_chain_capture,
		io_setup_shift_chain_update})) else $error("setup strobes overlap");
	a_capture_once: assert property (@(posedge tck) disable iff (!trst_n)
		io_setup_shift_chain_capture |=> !io_setup_shift_chain_capture)
		else $error("capture strobe longer than one clock");
	a_update_once: assert property (@(posedge tck) disable iff (!trst_n)
		io_setup_shift_chain_update |=> !io_setup_shift_chain_update &&
		!io_setup_shift_chain_capture) else $error("update strobe misplaced");
	a_serial_thru: assert property (@(posedge tck) disable iff (!trst_n)
		scan_serial_out == tdi) else $error("setup chain input not tdi");
	// Output enable is set on the falling edge after the state change
	a_oe_in_shift: assert property (@(negedge tck) disable iff (!trst_n)
		io_setup_shift_chain_shift |=> tdo_oe) else $error("tdo not driven");
	a_oe_off_idle: assert property (@(negedge tck) disable iff (!trst_n)
		(io_setup_shift_chain_capture || io_setup_shift_chain_update)
		|=> !tdo_oe) else $error("tdo driven outside shift");
	// ****************************************************************
	// System clock domain
	// ****************************************************************
	a_pulse_single: assert property (@(posedge ref_clk) disable iff (!reset_n)
		config_request_pulse |=> !config_request_pulse)
		else $error("reconfig pulse too long");
	a_freeze_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
		!clk_en |=> $stable(global_tristate)) else $error("tristate moved");
	c_capture: cover property (@(posedge tck) io_setup_shift_chain_capture);
	c_highz: cover property (@(posedge ref_clk) $rose(global_tristate));
	c_pulse: cover property (@(posedge ref_clk) config_request_pulse);
endmodule : bsr_scan_port_asserts
`default_nettype wire

/* tb/bsr_jtag_host.sv */
// Behavioural test-port host: makes the test clock and steers the lines.
`timescale 1ns/100ps
`default_nettype none
module bsr_jtag_host (
	// Test port lines
	output logic      tck,
	output logic      tms,
	output logic      tdi,
	input  wire logic tdo
);
	// ****************************************************************
	// Frames
	// ****************************************************************
	// Clock stands low between frames; pulled-up lines idle high
	initial begin
		tck = 1'h0;
		tms = 1'h1;
		tdi = 1'h1;
	end
	// One 30 ns clock; lines move with tck low, tdo taken at the rise
	task step(input logic m, input logic d, output logic o);
		tms = m;
		tdi = d;
		#15 o = tdo;
		tck = 1'h1;
		#15 tck = 1'h0;
	endtask : step
	// Shift n bits LSB first, then exit, update and return to idle
	task shift(input int n, input logic [63:0] din, output logic [63:0] dout);
		logic o;
		dout = '0;
		for (int k = 0; k < n; k++) begin
			step(k == n - 1, din[k], o);
			dout[k] = o;
		end
		step(1'h1, 1'h1, o);
		step(1'h0, 1'h1, o);
		// Idle clocks let the new instruction reach the mode flops
		step(1'h0, 1'h1, o);
		step(1'h0, 1'h1, o);
		tdi = 1'h1;
	endtask : shift
	task load_ir(input logic [9:0] code, output logic [63:0] cap);
		logic o;
		step(1'h1, 1'h1, o);
		step(1'h1, 1'h1, o);
		step(1'h0, 1'h1, o);
		step(1'h0, 1'h1, o);
		shift(10, {54'h0, code}, cap);
	endtask : load_ir
	task scan_dr(input int n, input logic [63:0] din, output logic [63:0] dout);
		logic o;
		step(1'h1, 1'h1, o);
		step(1'h0, 1'h1, o);
		step(1'h0, 1'h1, o);
		shift(n, din, dout);
	endtask : scan_dr
	// Five high clocks reach the reset state, then one low to idle
	task reset_tap;
		logic o;
		repeat (5) step(1'h1, 1'h1, o);
		step(1'h0, 1'h1, o);
	endtask : reset_tap
endmodule : bsr_jtag_host
`default_nettype wire

/* tb/testbench.sv */
// Self-checking bench of the boundary-scan test port.
`timescale 1ns/100ps
`default_nettype none
`include "bsr_defines.svh"
module testbench;
	localparam int NU = 4;
	localparam int CL = 3 * (NU + 16);
	localparam logic [31:0] IDV = 32'h1234_5001; // Arbitrary value
	localparam logic [31:0] UCV = 32'h0BAD_CAFE; // Arbitrary value
	logic ref_clk = 1'h0, clk_en = 1'h1, reset_n, trst_n;
	logic tck, tms, tdi, tdo, tdo_oe, global_tristate, config_request_pulse;
	logic [NU-1:0] core_output_value = '0, core_output_enable = '0;
	logic [NU-1:0] pad_input_value = '0, core_input_override;
	logic [NU-1:0] pad_output_drive, pad_enable_drive;
	logic [3:0] clkin_pad_value = '0;
	logic [7:0] ctrl_in_pad_value = '0;
	logic [1:0] od_core_enable = '0, od_pad_value = '0;
	logic cfgclk_core_value = 1'h0, cfgclk_core_enable = 1'h0;
	logic cfgclk_pad_value = 1'h0, scan_serial_in = 1'h0;
	logic [0:0] dout_core_value = '0;
	logic io_setup_shift_chain_shift, io_setup_shift_chain_capture;
	logic io_setup_shift_chain_update, scan_serial_out;
	int seed = 23739, failures = 0, checks_done = 0, cycles = 0, pulses = 0;
	logic [9:0] codes [5] = '{`BSR_OP_BYPASS, `BSR_OP_HIGHZ, `BSR_OP_CLAMP,
		10'h2A5, `BSR_OP_RECONFIG};
	// ****************************************************************
	// Design, host and setup-chain stand-in
	// ****************************************************************
	always #2.5 ref_clk = ~ref_clk;
	bsr_scan_port #(.CHAIN_LEN(CL), .ID_VALUE(IDV), .USER_VALUE(UCV)) i_dut (
		.ref_clk, .reset_n, .clk_en, .tck, .trst_n, .tms, .tdi, .tdo,
		.tdo_oe, .core_output_value, .core_output_enable, .pad_input_value,
		.pad_output_drive, .pad_enable_drive, .core_input_override,
		.global_tristate, .clkin_pad_value, .ctrl_in_pad_value,
		.od_core_enable, .od_pad_value, .cfgclk_core_value,
		.cfgclk_core_enable, .cfgclk_pad_value, .dout_core_value,
		.config_request_pulse, .io_setup_shift_chain_shift,
		.io_setup_shift_chain_capture, .io_setup_shift_chain_update,
		.scan_serial_out, .scan_serial_in);
	bsr_jtag_host i_host (.tck, .tms, .tdi, .tdo);
	// One-bit setup chain closes the loop back to the port
	always @(posedge tck) begin
		if (io_setup_shift_chain_shift) scan_serial_in <= scan_serial_out;
	end
	// Pulse count and hang guard
	always @(posedge ref_clk) begin
		cycles++;
		if (config_request_pulse === 1'h1) pulses++;
		if (cycles == 30000) begin
			failures++;
			conclude();
		end
	end
	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic [NU-1:0] field(input logic [63:0] v, input int b);
		for (int i = 0; i < NU; i++) field[i] = v[3*i+b];
	endfunction : field
	// Chain image: user cells, then dedicated cells, all but the cfgclk cell with fixed bits
	function automatic logic [63:0] chain_exp();
		logic [63:0] v;
		logic [11:0] ded;
		v = '0;
		ded = {ctrl_in_pad_value, clkin_pad_value};
		for (int i = 0; i < NU; i++) v[3*i +: 3] = {core_output_value[i],
			core_output_enable[i], pad_input_value[i]};
		for (int i = 0; i < 12; i++) v[3*(NU+i) +: 3] = {2'h1, ded[i]};
		for (int i = 0; i < 2; i++) v[3*(NU+12+i) +: 3] = {1'h0,
			od_core_enable[i], od_pad_value[i]};
		v[3*(NU+14) +: 3] = {cfgclk_core_value, cfgclk_core_enable,
			cfgclk_pad_value};
		v[3*(NU+15) +: 3] = {dout_core_value, 2'h0};
		return v;
	endfunction : chain_exp
	task check(input string what, input logic [63:0] e, input logic [63:0] g);
		checks_done++;
		if (g !== e) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", what, e, g);
		end
	endtask : check
	// Pins move on the falling edge, then settle past the synchronisers
	task set_pins;
		@(negedge ref_clk);
		{core_output_value, core_output_enable, pad_input_value} = 12'($random(seed));
		{clkin_pad_value, ctrl_in_pad_value, od_core_enable} = 14'($random(seed));
		{od_pad_value, cfgclk_core_value, cfgclk_core_enable} = 4'($random(seed));
		{cfgclk_pad_value, dout_core_value} = 2'($random(seed));
		#200;
	endtask : set_pins
	task conclude;
		$display("checks %0d mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : conclude
	// ****************************************************************
	// Scenarios
	// ****************************************************************
	initial begin
		logic [63:0] d, q, p;
		logic hz, cl;
		// A real falling edge, so the asynchronous resets do trigger
		#1;
		reset_n = 1'h0;
		trst_n = 1'h0;
		repeat (3) @(posedge ref_clk);
		@(negedge ref_clk);
		reset_n = 1'h1;
		trst_n = 1'h1;
		i_host.reset_tap();
		check("tdo_oe idle", 64'h0, 64'(tdo_oe));
		i_host.scan_dr(32, 64'h0, q);
		check("idcode", 64'(IDV), q);
		i_host.load_ir(`BSR_OP_USERCODE, q);
		check("ir capture", 64'(`BSR_IR_CAPTURE), q);
		i_host.scan_dr(32, 64'h0, q);
		check("usercode", 64'(UCV), q);
		$display("identity test done");
		set_pins();
		p = {$random(seed), $random(seed)} & ((64'h1 << CL) - 64'h1);
		i_host.load_ir(`BSR_OP_SAMPLE, q);
		i_host.scan_dr(CL, p, q);
		check("sample", chain_exp(), q);
		check("functional", 64'(core_output_value), 64'(pad_output_drive));
		i_host.load_ir(`BSR_OP_EXTEST, q);
		check("ext out", 64'(field(p, 2)), 64'(pad_output_drive));
		check("ext oe", 64'(field(p, 1)), 64'(pad_enable_drive));
		check("ext in", 64'(field(p, 0)), 64'(core_input_override));
		set_pins();
		i_host.scan_dr(CL, p, q);
		check("extest", chain_exp(), q);
		$display("boundary test done");
		@(negedge ref_clk) clk_en = 1'h0;
		repeat (4) @(negedge ref_clk);
		clk_en = 1'h1;
		foreach (codes[k]) begin
			i_host.load_ir(codes[k], q);
			d = 64'(16'($random(seed)));
			i_host.scan_dr(16, d, q);
			check("bypass", (d << 1) & 64'h0000_0000_0000_FFFF, q);
			hz = codes[k] == `BSR_OP_HIGHZ;
			cl = codes[k] == `BSR_OP_CLAMP;
			check("tristate", 64'(hz), 64'(global_tristate));
			check("enable", 64'(hz ? {NU{1'h0}} : cl ? field(p, 1) :
				core_output_enable), 64'(pad_enable_drive));
			if (!hz) check("drive", 64'(cl ? field(p, 2) : core_output_value),
				64'(pad_output_drive));
		end
		check("reconfig pulses", 64'h1, 64'(pulses));
		$display("bypass test done");
		i_host.load_ir(`BSR_OP_CONFIG_IO, q);
		d = 64'(8'($random(seed)));
		i_host.scan_dr(8, d, q);
		check("setup chain", d[6:0], q[7:1]);
		i_host.reset_tap();
		i_host.scan_dr(32, 64'h0, q);
		check("idcode again", 64'(IDV), q);
		$display("setup chain test done");
		conclude();
	end
endmodule : testbench
bind bsr_scan_port bsr_scan_port_asserts i_chk (.ref_clk, .reset_n, .clk_en,
	.global_tristate, .config_request_pulse, .tck, .trst_n, .tdi, .tdo_oe,
	.io_setup_shift_chain_shift, .io_setup_shift_chain_capture,
	.io_setup_shift_chain_update, .scan_serial_out);
`default_nettype wire
